// ### logic/clf_top.sv
// Loop filter, external generator enables and monitor reference divider.
module clf_top #(
  parameter int LONG_W = clf_pkg::LONG_DIV_W // Long divider width.
) (
  input wire logic MCLK, // 20 MHz system clock.
  input wire logic SYS_RST, // Synchronous reset, active high.
  input wire logic CMP_DONE, // One-cycle pulse, comparison finished.
  input wire logic [2:0] CMP_BAND, // Comparator band code.
  input wire logic EXT_GEN_ON_BIT, // External generator on control bit.
  input wire logic GENERATOR_STOP, // Generator stop signal.
  input wire logic CRYSTAL_MODE_EN, // Crystal enable configuration bit.
  input wire logic SLOW_CRYSTAL_SEL, // Slow crystal configuration bit.
  input wire logic MONITOR_ON_BIT, // Clock monitor enable.
  input wire logic EXT_INACTIVE_FLAG, // External inactivity indicator.
  input wire logic EXTERNAL_CLOCK, // External clock, asynchronous.
  input wire logic INTERNAL_BASE_CLOCK, // Base clock, asynchronous.
  output logic [3:0] OSC_DIVIDER_CTRL, // Effective divider control.
  output logic [7:0] OSC_STAGE_CTRL, // Stage control.
  output logic [11:0] CTRL_WORD, // Raw filter word.
  output logic FILTER_STABLE, // Error within five percent.
  output logic EXT_GEN_ENABLE, // External generator enable.
  output logic AMP_ENABLE, // Crystal amplifier enable.
  output logic AMP_LOW_GAIN, // Reduced amplifier gain.
  output logic OSC_PIN_IN_PORT, // First pin in port use.
  output logic OSC_PIN_OUT_PORT, // Second pin in port use.
  output logic EXT_PATH_ENABLE, // External input path enable.
  output logic MONITOR_ACTIVE, // Monitor checking both clocks.
  output logic EXT_REFERENCE, // External reference clock.
  output logic INT_REFERENCE, // Internal reference clock.
  output logic EXT_STABILIZE_CLOCK, // Stabilization clock.
  output logic EXT_STABLE_FLAG // External clock stable.
);
  ////////////////////////////////////////////////////////////////////////
  clf_edge_if eg();
  clf_edge_sync u_sync (
    .mclk(MCLK),
    .sys_rst(SYS_RST),
    .ext_in(EXTERNAL_CLOCK),
    .base_in(INTERNAL_BASE_CLOCK),
    .eo(eg)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [11:0] word_q;
  logic [11:0] word_d;
  logic stable_q;
  clf_pkg::clf_band_t band;
  assign band = clf_pkg::clf_band_t'(CMP_BAND);

  // Signed step chosen by band; one 12-bit add lets stage carries reach the divider.
  always_comb begin
    word_d = word_q;
    if (CMP_DONE) begin
      case (band)
        clf_pkg::CLF_BAND_LO_BIG: word_d = word_q - clf_pkg::STEP_BIG;
        clf_pkg::CLF_BAND_LO_MID: word_d = word_q - clf_pkg::STEP_MID;
        clf_pkg::CLF_BAND_LO_ONE: word_d = word_q - clf_pkg::STEP_ONE;
        clf_pkg::CLF_BAND_HI_ONE: word_d = word_q + clf_pkg::STEP_ONE;
        clf_pkg::CLF_BAND_HI_MID: word_d = word_q + clf_pkg::STEP_MID;
        clf_pkg::CLF_BAND_HI_BIG: word_d = word_q + clf_pkg::STEP_BIG;
        default: word_d = word_q;
      endcase
    end
  end

  // Word updates only on a finished comparison; wrap is left alone on purpose.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      word_q <= clf_pkg::CTRL_RESET;
    end else begin
      word_q <= word_d;
    end
  end

  // Stable indication follows the latest comparison result.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      stable_q <= 1'b0;
    end else if (CMP_DONE) begin
      stable_q <= (band == clf_pkg::CLF_BAND_LO_ONE) || (band == clf_pkg::CLF_BAND_HI_ONE);
    end
  end

  // Divider codes A through F are folded onto the slowest setting.
  always_comb begin
    OSC_DIVIDER_CTRL = word_q[11:8];
    if (word_q[11:8] > clf_pkg::DIV_SLOWEST) begin
      OSC_DIVIDER_CTRL = clf_pkg::DIV_SLOWEST;
    end
  end
  assign OSC_STAGE_CTRL = word_q[7:0];
  assign CTRL_WORD = word_q;
  assign FILTER_STABLE = stable_q;

  ////////////////////////////////////////////////////////////////////////
  logic gen_en;
  assign gen_en = EXT_GEN_ON_BIT & ~GENERATOR_STOP;
  assign EXT_GEN_ENABLE = gen_en;
  assign AMP_ENABLE = gen_en & CRYSTAL_MODE_EN;
  assign OSC_PIN_OUT_PORT = ~(gen_en & CRYSTAL_MODE_EN);
  assign EXT_PATH_ENABLE = gen_en;
  assign OSC_PIN_IN_PORT = ~gen_en;
  assign AMP_LOW_GAIN = SLOW_CRYSTAL_SEL;
  assign MONITOR_ACTIVE = MONITOR_ON_BIT & gen_en;

  ////////////////////////////////////////////////////////////////////////
  logic [LONG_W-1:0] long_q;
  logic [1:0] ext4_q;
  logic [1:0] base4_q;
  logic ext_stable_q;
  logic stab_q;
  logic long_tick;
  logic stab_tap;
  logic ext_ref_q;
  logic int_ref_q;
  // Timer counts the external clock before stable; after, the path chosen by slow bit.
  assign long_tick = ~ext_stable_q ? eg.ext_fall
                   : (SLOW_CRYSTAL_SEL ? eg.base_fall : eg.ext_fall);

  // Long divider cleared while generator enable is low.
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !gen_en) begin
      long_q <= '0;
    end else if (long_tick) begin
      long_q <= long_q + 1'b1;
    end
  end

  // Divide-by-four stages always run on both clocks.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ext4_q <= 2'h0;
      base4_q <= 2'h0;
    end else begin
      if (eg.ext_fall) ext4_q <= ext4_q + 2'h1;
      if (eg.base_fall) base4_q <= base4_q + 2'h1;
    end
  end

  // Stabilization tap: bit for 16 or 4096 counts.
  assign stab_tap = CRYSTAL_MODE_EN ? long_q[clf_pkg::STAB_LONG_BIT]
                                    : long_q[clf_pkg::STAB_SHORT_BIT];

  // Falling tap sets the flag; clear conditions override.
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !gen_en) begin
      stab_q <= 1'b0;
      ext_stable_q <= 1'b0;
    end else begin
      stab_q <= stab_tap;
      if (EXT_INACTIVE_FLAG) begin
        ext_stable_q <= 1'b0;
      end else if (stab_q && !stab_tap) begin
        ext_stable_q <= 1'b1;
      end
    end
  end

  // References: long divider on the path picked by the slow bit.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ext_ref_q <= 1'b0;
      int_ref_q <= 1'b0;
    end else begin
      ext_ref_q <= SLOW_CRYSTAL_SEL ? ext4_q[1] : long_q[LONG_W-1];
      int_ref_q <= SLOW_CRYSTAL_SEL ? long_q[LONG_W-1] : base4_q[1];
    end
  end
  assign EXT_REFERENCE = ext_ref_q;
  assign INT_REFERENCE = int_ref_q;
  assign EXT_STABILIZE_CLOCK = stab_q;
  assign EXT_STABLE_FLAG = ext_stable_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the filter, the enables and the monitor divider.
  hold_word_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !CMP_DONE |=> $stable(word_q)) else $error("word moved without comparison");
  big_down_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CMP_DONE && band == clf_pkg::CLF_BAND_LO_BIG |=> word_q == $past(word_q) - 12'h020)
    else $error("big down step wrong");
  mid_up_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CMP_DONE && band == clf_pkg::CLF_BAND_HI_MID |=> word_q == $past(word_q) + 12'h008)
    else $error("mid up step wrong");
  div_fold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    word_q[11:8] > 4'h9 |-> OSC_DIVIDER_CTRL == 4'h9) else $error("divider not folded");
  stable_band_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CMP_DONE && band == clf_pkg::CLF_BAND_LO_BIG |=> !FILTER_STABLE)
    else $error("stable at large error");
  amp_gate_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    AMP_ENABLE == (EXT_GEN_ON_BIT && !GENERATOR_STOP && CRYSTAL_MODE_EN))
    else $error("amplifier enable wrong");
  div_reset_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !gen_en |=> long_q == '0 && !EXT_STABLE_FLAG) else $error("divider not held");
  inact_clear_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    EXT_INACTIVE_FLAG |=> !EXT_STABLE_FLAG) else $error("stable kept on inactivity");
  stable_rise_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    $rose(ext_stable_q) |-> $past(stab_q) && !$past(stab_tap))
    else $error("stable rose without tap fall");
  flag_set_c: cover property (@(posedge MCLK) disable iff (SYS_RST) $rose(EXT_STABLE_FLAG));
  fold_c: cover property (@(posedge MCLK) disable iff (SYS_RST) word_q[11:8] > 4'h9);
  filt_c: cover property (@(posedge MCLK) disable iff (SYS_RST) $rose(FILTER_STABLE));
  relapse_c: cover property (@(posedge MCLK) disable iff (SYS_RST) $fell(EXT_STABLE_FLAG));
endmodule // clf_top

// ### logic/clf_pkg.sv
// Package of constants shared by the clock loop filter and monitor divider.
// Summary of operation
// - Divider and stage controls form one 12-bit word, divider bits on top.
// - Below nominal subtract 32, 8 or 1 according to the error band.
// - Above nominal add 1, 8 or 32 according to the error band.
// - Overflow or underflow gives divider A-F, treated exactly like 9.
// - Recovery uses ordinary subtraction steps; divider A-F settling is acceptable.
// - Filter-stable is asserted while error is within five percent.
// - Slow-crystal bit set selects reduced amplifier gain, clear selects megahertz gain.
// - Crystal amplifier on only with generator enable and crystal-enable both set.
// - External input path on whenever generator enable is set, else port function.
// - When enabled the monitor checks both clocks for activity.
// - External reference from external clock; internal from base clock, but from external clock while slow bit set and not yet stable.
// - External reference at most half base clock, internal at most half external.
// - Both clocks always divided by four; long divider on one, by slow bit.
// - Long divider divides by 4096 and doubles as stabilization timer.
// - Long divider held in reset whenever generator enable is clear.
// - Before stable, divider counts external clock; tap 16 or 4096 by crystal mode.
// - Falling edge of stabilization clock sets the external-stable flag.
// - Once stable, the long divider returns to reference dividing.
// - Stable flag cleared by inactivity returns divider to timer operation.
// - Generator enable equals generator-on bit and not generator stop.
// - Stable flag cleared when generator enable clear or inactivity flag set.
package clf_pkg;
  localparam int CTRL_W = 12;
  localparam int DIV_W = 4;
  localparam int STG_W = 8;
  localparam logic [11:0] CTRL_RESET = 12'h800;
  localparam logic [3:0] DIV_SLOWEST = 4'h9;
  localparam logic [11:0] STEP_BIG = 12'h020;
  localparam logic [11:0] STEP_MID = 12'h008;
  localparam logic [11:0] STEP_ONE = 12'h001;
  localparam int LONG_DIV_W = 12;
  localparam int SHORT_DIV_W = 2;
  localparam int STAB_SHORT_BIT = 3;
  localparam int STAB_LONG_BIT = 11;
  // Comparator band codes, one per row of the correction table.
  typedef enum logic [2:0] {
    CLF_BAND_LO_BIG, CLF_BAND_LO_MID, CLF_BAND_LO_ONE,
    CLF_BAND_HI_ONE, CLF_BAND_HI_MID, CLF_BAND_HI_BIG
  } clf_band_t;
endpackage

// ### logic/clf_edge_if.sv
// Interface carrying the synchronised sampled clocks and their edges.
interface clf_edge_if;
  logic ext_lvl;
  logic base_lvl;
  logic ext_fall;
  logic base_fall;
  modport src (output ext_lvl, base_lvl, ext_fall, base_fall);
  modport dst (input ext_lvl, base_lvl, ext_fall, base_fall);
endinterface

// ### logic/clf_edge_sync.sv
// Two-stage synchroniser and falling-edge detector for the sampled clocks.
module clf_edge_sync (
  input wire logic mclk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic ext_in, // External clock from the pin path.
  input wire logic base_in, // Base clock from the oscillator.
  clf_edge_if.src eo // Synchronised levels and edges.
);
  logic [1:0] ext_s_q;
  logic [1:0] base_s_q;
  logic ext_d3_q;
  logic base_d3_q;
  // The first stage feeds only the second; edges use later stages.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_s_q <= 2'h0;
      base_s_q <= 2'h0;
      ext_d3_q <= 1'b0;
      base_d3_q <= 1'b0;
    end else begin
      ext_s_q <= {ext_s_q[0], ext_in};
      base_s_q <= {base_s_q[0], base_in};
      ext_d3_q <= ext_s_q[1];
      base_d3_q <= base_s_q[1];
    end
  end
  assign eo.ext_lvl = ext_s_q[1];
  assign eo.base_lvl = base_s_q[1];
  assign eo.ext_fall = ext_d3_q & ~ext_s_q[1];
  assign eo.base_fall = base_d3_q & ~base_s_q[1];
endmodule // clf_edge_sync

// ### verif/clf_partner.sv
// Behavioural far side: external clock source and base clock source.
module clf_partner (
  input wire logic mclk, // System clock.
  input wire logic run, // External input path enabled.
  output logic ext_clk, // External clock, held low while off.
  output logic base_clk, // Base clock, free running.
  output int falls // External falling edges since enable.
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  ////////////////////////////////////////////////////////////
  // External period is 8 MCLK and base 16 MCLK, slow enough for the syncs.
  always @(posedge mclk) begin
    ph <= ph + 1;
    base_clk <= ph[3];
    ext_clk <= run & ph[2];
    if (!run) begin
      falls <= 0;
    end else if (ext_clk & ~ph[2]) begin
      falls <= falls + 1;
    end
  end
endmodule // clf_partner

// ### verif/clf_top_tb.sv
// Self-checking testbench for the loop filter and monitor divider.
module clf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK, SYS_RST, CMP_DONE, EGO, STP, XT, SLW, MON, INA;
  logic [2:0] CMP_BAND;
  logic [3:0] DIV;
  logic [7:0] STG;
  logic [11:0] WRD;
  logic FST, GEN, AMP, LOWG, PIN_IN, PIN_OUT, PATH, MACT, EXT_REFERENCE_O, INT_REFERENCE_O, STBC, FLG, ECK, BCK;
  int falls;
  int err_total = 0;
  int total_checks = 0;
  // Signed corrections per band code as 12-bit wrap values.
  localparam logic [11:0] DT [8] = '{12'hFE0, 12'hFF8, 12'hFFF, 12'h001,
                                     12'h008, 12'h020, 12'h000, 12'h000};
  clf_top #(.LONG_W(12)) uut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CMP_DONE(CMP_DONE),
    .CMP_BAND(CMP_BAND), .EXT_GEN_ON_BIT(EGO), .GENERATOR_STOP(STP),
    .CRYSTAL_MODE_EN(XT), .SLOW_CRYSTAL_SEL(SLW), .MONITOR_ON_BIT(MON),
    .EXT_INACTIVE_FLAG(INA), .EXTERNAL_CLOCK(ECK), .INTERNAL_BASE_CLOCK(BCK),
    .OSC_DIVIDER_CTRL(DIV), .OSC_STAGE_CTRL(STG), .CTRL_WORD(WRD), .FILTER_STABLE(FST),
    .EXT_GEN_ENABLE(GEN), .AMP_ENABLE(AMP), .AMP_LOW_GAIN(LOWG), .OSC_PIN_IN_PORT(PIN_IN),
    .OSC_PIN_OUT_PORT(PIN_OUT), .EXT_PATH_ENABLE(PATH), .MONITOR_ACTIVE(MACT),
    .EXT_REFERENCE(EXT_REFERENCE_O), .INT_REFERENCE(INT_REFERENCE_O), .EXT_STABILIZE_CLOCK(STBC),
    .EXT_STABLE_FLAG(FLG));
  clf_partner far (.mclk(MCLK), .run(PATH), .ext_clk(ECK), .base_clk(BCK), .falls(falls));
  ////////////////////////////////////////////////////////////
  // Clock and shared helpers; inputs move 1 ns after each rising edge.
  initial begin
    MCLK = 0;
    forever #25 MCLK = ~MCLK;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic [2:0] b);
    CMP_DONE = 1;
    CMP_BAND = b;
    cyc(1);
    CMP_DONE = 0;
    cyc(1);
  endtask
  // Bounded wait, so a dead external path cannot hang the run.
  task automatic wait_falls(input int n);
    for (int k = 0; k < 40000 && falls < n; k++) cyc(1);
  endtask
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Every band once from the reset word, including the ignored codes.
  task automatic t_filter();
    logic [11:0] w;
    w = 12'h800;
    chk(WRD, w);
    chk(FST, 0);
    for (int b = 0; b < 8; b++) begin
      step(b[2:0]);
      w = w + DT[b];
      chk(WRD, w);
      chk({DIV, STG}, w);
      chk(FST, b == 2 || b == 3);
    end
  endtask
  // Underflow past zero, then one recovery step while the divider reads as slowest.
  task automatic t_wrap();
    repeat (64) step(3'h0);
    chk(WRD, 12'h000);
    step(3'h0);
    chk(WRD, 12'hFE0);
    chk(DIV, 4'h9);
    step(3'h0);
    chk({DIV, STG}, 12'h9C0);
  endtask
  // All enable combinations; these outputs are combinational.
  task automatic t_enables();
    logic g;
    for (int i = 0; i < 32; i++) begin
      {EGO, STP, XT, SLW, MON} = i[4:0];
      cyc(1);
      g = i[4] & ~i[3];
      chk(GEN, g);
      chk({AMP, PIN_OUT}, {g & i[2], ~(g & i[2])});
      chk({PATH, PIN_IN}, {g, ~g});
      chk(LOWG, i[1]);
      chk(MACT, i[0] & g);
    end
  endtask
  // Flag must stay low one fall short of the count and rise after it.
  task automatic t_stab(input logic xtal, input int n);
    {EGO, STP, XT, SLW, MON, INA} = {1'b0, 1'b0, xtal, 3'b000};
    cyc(6);
    chk(FLG, 0);
    EGO = 1;
    wait_falls(n - 1);
    cyc(6);
    chk(FLG, 0);
    chk(STBC, 1);
    wait_falls(n);
    cyc(7);
    chk(FLG, 1);
    chk(STBC, 0);
  endtask
  // The divided-by-four side toggles often, the long-divided side hardly.
  task automatic t_refs(input logic slow);
    int ne;
    int ni;
    logic pe;
    logic pi;
    SLW = slow;
    ne = 0;
    ni = 0;
    cyc(8);
    for (int k = 0; k < 256; k++) begin
      pe = EXT_REFERENCE_O;
      pi = INT_REFERENCE_O;
      cyc(1);
      ne += int'(EXT_REFERENCE_O !== pe);
      ni += int'(INT_REFERENCE_O !== pi);
    end
    chk({ne > 4, ni > 4}, {slow, ~slow});
  endtask
  // Inactivity clears the flag; software then drops the monitor.
  task automatic t_clear();
    MON = 1;
    INA = 1;
    cyc(2);
    chk(FLG, 0);
    MON = 0;
    INA = 0;
    STP = 1;
    cyc(2);
    chk({GEN, FLG}, 0);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence, and a watchdog sized well past the longest count.
  initial begin
    {SYS_RST, CMP_DONE, CMP_BAND, EGO, STP, XT, SLW, MON, INA} = 11'h400;
    cyc(5);
    SYS_RST = 0;
    t_filter();
    t_wrap();
    t_enables();
    t_stab(0, 16);
    t_refs(1);
    t_refs(0);
    t_clear();
    t_stab(1, 4096);
    complete_run();
  end
  initial begin
    #4000000;
    err_total++;
    complete_run();
  end
endmodule // clf_top_tb
